// >>> design/spm_master.sv
// Purpose: SPI master with programmable serial clock and chip-select
//          delays around each character (clock phase 0).
// Assumes: Configuration words are steady while a character runs.
// Notes:   Eight-bit characters, most significant bit first.
//
// Notes on behaviour
// R01: Serial period is prescale plus one; zero gives two.
// R02: Prescale sits in format bits 15 to 8.
// R03: Polarity bit 17 sets idle level, active edge.
// R04: Master bit 0 enables; phase bit 16 must be 0.
// R05: Select-to-first-edge wait is delay plus 2 or 3.
// R06: Half period, then delay plus one, then release.
// R07: Delay word carries both chip-select delay counts.
// R08: Software keeps serial period above interface minimum.
`timescale 1ns/1ps
module spm_master
(
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    // Configuration
    input  wire logic [31:0] i_global_control_one,
    input  wire logic [31:0] i_data_format_select,
    input  wire logic [31:0] i_delay_config,
    input  wire logic        i_chip_select_keep,
    // Character request and result
    input  wire logic        i_start,
    input  wire logic [7:0]  i_tx_data,
    output logic [7:0]       o_rx_data,
    output logic             o_done,
    output logic             o_busy,
    // Serial pins
    output logic             o_serial_clock_pin,
    output logic             o_mosi,
    input  wire logic        i_miso,
    output logic             o_cs_n
);

    spm_pkg::spm_state_t state_q;
    logic [8:0]  cnt_q;
    logic [3:0]  bits_q;
    logic [7:0]  tx_q;
    logic [7:0]  rx_q;
    logic [7:0]  prescale_q;
    logic        polarity_q;
    logic        keep_q;
    logic        sclk_q;
    logic        mosi_q;
    logic        cs_n_q;
    logic        done_q;
    logic        miso_meta_q;
    logic        miso_sync_q;
    logic        div_half;
    logic        div_full;
    logic        enabled;
    logic        go;
    logic [8:0]  c2t;
    logic [8:0]  t2c;
    logic [8:0]  lead_len;

    // ****************************************************************
    // Configuration decode
    // ****************************************************************
    assign enabled = i_global_control_one[spm_pkg::GCR_MASTER_BIT] // R04
                  && !i_data_format_select[spm_pkg::FMT_PHASE_BIT]; // R04
    assign go      = i_start && enabled;
    // Both delay counts come from the one delay word
    assign c2t = {1'b0, i_delay_config[spm_pkg::DLY_C2T_MSB: // R07
                                       spm_pkg::DLY_C2T_LSB]};
    assign t2c = {1'b0, i_delay_config[spm_pkg::DLY_T2C_MSB: // R07
                                       spm_pkg::DLY_T2C_LSB]};
    // Lead wait depends on keep at the time of the request
    assign lead_len = keep_q ? c2t + spm_pkg::LEAD_EXTRA_KEEP  // R05
                             : c2t + spm_pkg::LEAD_EXTRA_FREE; // R05

    // ****************************************************************
    // Prescaler, running only while bits are shifted
    // ****************************************************************
    spm_clk_div u_div
    (
        .i_sys_clk  (i_sys_clk),
        .i_rst_n    (i_rst_n),
        .i_run      (state_q == spm_pkg::SPM_SHIFT),
        .i_prescale (prescale_q),
        .o_half     (div_half),
        .o_full     (div_full)
    );

    // ****************************************************************
    // Input synchroniser for the slave data line
    // ****************************************************************
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            miso_meta_q <= 1'b0;
            miso_sync_q <= 1'b0;
        end
        else
        begin
            miso_meta_q <= i_miso;
            miso_sync_q <= miso_meta_q;
        end
    end

    // ****************************************************************
    // Per-character settings captured at the request
    // ****************************************************************
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            prescale_q <= 8'h00;
            polarity_q <= 1'b0;
            keep_q     <= 1'b0;
        end
        else if (go && (state_q == spm_pkg::SPM_IDLE
                     || state_q == spm_pkg::SPM_HOLD))
        begin
            prescale_q <= i_data_format_select[ // R02
                spm_pkg::FMT_PRESCALE_MSB:spm_pkg::FMT_PRESCALE_LSB];
            polarity_q <= i_data_format_select[
                spm_pkg::FMT_POLARITY_BIT]; // R03
            keep_q     <= i_chip_select_keep;
        end
        else if (state_q == spm_pkg::SPM_IDLE)
        begin
            // Idle level follows the polarity bit in idle, not while select is held
            polarity_q <= i_data_format_select[
                spm_pkg::FMT_POLARITY_BIT]; // R03
        end
    end

    // ****************************************************************
    // Sequencer: lead delay, shifting, tail delay, optional hold
    // ****************************************************************
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            state_q <= spm_pkg::SPM_IDLE;
            cnt_q   <= 9'h000;
            cs_n_q  <= spm_pkg::CS_N_RESET;
            done_q  <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            case (state_q)
                spm_pkg::SPM_IDLE:
                begin
                    cs_n_q <= 1'b1;
                    if (go)
                    begin
                        cs_n_q  <= 1'b0;
                        cnt_q   <= 9'h000;
                        state_q <= spm_pkg::SPM_LEAD;
                    end
                end
                spm_pkg::SPM_LEAD:
                begin
                    cnt_q <= cnt_q + 9'h001;
                    if (cnt_q == lead_len - 9'h001) // R05
                    begin
                        state_q <= spm_pkg::SPM_SHIFT;
                    end
                end
                spm_pkg::SPM_SHIFT:
                begin
                    // Full period after last leading edge: half hold
                    if (div_full && bits_q == spm_pkg::CHAR_BITS_CNT)
                    begin
                        cnt_q  <= 9'h000;
                        done_q <= 1'b1;
                        state_q <= keep_q ? spm_pkg::SPM_HOLD  // R06
                                          : spm_pkg::SPM_TAIL; // R06
                    end
                end
                spm_pkg::SPM_TAIL:
                begin
                    cnt_q <= cnt_q + 9'h001;
                    if (cnt_q == t2c + spm_pkg::TAIL_EXTRA - 9'h001) // R06
                    begin
                        cs_n_q  <= 1'b1;
                        state_q <= spm_pkg::SPM_IDLE;
                    end
                end
                spm_pkg::SPM_HOLD:
                begin
                    cnt_q <= 9'h000;
                    if (go)
                    begin
                        state_q <= spm_pkg::SPM_LEAD;
                    end
                    else if (!i_chip_select_keep || !enabled)
                    begin
                        state_q <= spm_pkg::SPM_TAIL;
                    end
                end
                default:
                begin
                    state_q <= spm_pkg::SPM_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Serial clock: leading edge at lead end and at each period end but the last
    // ****************************************************************
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            sclk_q <= 1'b0;
        end
        else if (state_q == spm_pkg::SPM_LEAD
              && cnt_q == lead_len - 9'h001)
        begin
            sclk_q <= !polarity_q; // R03
        end
        else if (state_q == spm_pkg::SPM_SHIFT && div_full
              && bits_q != spm_pkg::CHAR_BITS_CNT)
        begin
            sclk_q <= !polarity_q; // R01
        end
        else if (state_q == spm_pkg::SPM_SHIFT && div_half)
        begin
            sclk_q <= polarity_q; // R03
        end
        else if (state_q != spm_pkg::SPM_SHIFT)
        begin
            sclk_q <= polarity_q; // R03
        end
    end

    // ****************************************************************
    // Data path: sample on leading edge, shift on trailing edge
    // ****************************************************************
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            bits_q <= 4'h0;
            tx_q   <= 8'h00;
            rx_q   <= spm_pkg::RX_RESET;
            mosi_q <= 1'b0;
        end
        else if (go && (state_q == spm_pkg::SPM_IDLE
                     || state_q == spm_pkg::SPM_HOLD))
        begin
            // First bit valid before the first edge
            bits_q <= 4'h0;
            tx_q   <= {i_tx_data[6:0], 1'b0};
            mosi_q <= i_tx_data[7];
        end
        else if ((state_q == spm_pkg::SPM_LEAD
               && cnt_q == lead_len - 9'h001)
              || (state_q == spm_pkg::SPM_SHIFT && div_full
               && bits_q != spm_pkg::CHAR_BITS_CNT))
        begin
            rx_q   <= {rx_q[6:0], miso_sync_q};
            bits_q <= bits_q + 4'h1;
        end
        else if (state_q == spm_pkg::SPM_SHIFT && div_half
              && bits_q != spm_pkg::CHAR_BITS_CNT)
        begin
            mosi_q <= tx_q[7];
            tx_q   <= {tx_q[6:0], 1'b0};
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign o_serial_clock_pin = sclk_q;
    assign o_mosi             = mosi_q;
    assign o_cs_n             = cs_n_q;
    assign o_rx_data          = rx_q;
    assign o_done             = done_q;
    assign o_busy             = (state_q == spm_pkg::SPM_LEAD)
                             || (state_q == spm_pkg::SPM_SHIFT)
                             || (state_q == spm_pkg::SPM_TAIL);

endmodule

// >>> design/spm_pkg.sv
// Purpose: Shared constants for the SPI master chip-select and clock
//          timing block.
// Assumes: One interface clock; configuration words arrive as plain ports.
// Notes:   Field positions, cycle counts and two reset values live here; the checker repeats some.
package spm_pkg;

    // ****************************************************************
    // Configuration word layout
    // ****************************************************************
    localparam int unsigned GCR_MASTER_BIT    = 0;
    localparam int unsigned FMT_PRESCALE_LSB  = 8;
    localparam int unsigned FMT_PRESCALE_MSB  = 15;
    localparam int unsigned FMT_PHASE_BIT     = 16;
    localparam int unsigned FMT_POLARITY_BIT  = 17;
    localparam int unsigned DLY_T2C_LSB       = 16;
    localparam int unsigned DLY_T2C_MSB       = 23;
    localparam int unsigned DLY_C2T_LSB       = 24;
    localparam int unsigned DLY_C2T_MSB       = 31;

    // ****************************************************************
    // Timing figures, in interface clock cycles except the clock period in ns
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS     = 40;
    localparam logic [8:0]  LEAD_EXTRA_FREE   = 9'h002;
    localparam logic [8:0]  LEAD_EXTRA_KEEP   = 9'h003;
    localparam logic [8:0]  TAIL_EXTRA        = 9'h001;
    localparam logic [8:0]  MIN_PERIOD        = 9'h002;

    // ****************************************************************
    // Character size and reset values
    // ****************************************************************
    localparam int unsigned CHAR_BITS         = 8;
    localparam logic [3:0]  CHAR_BITS_CNT     = 4'h8;
    localparam logic [7:0]  RX_RESET          = 8'h00;
    localparam logic        CS_N_RESET        = 1'b1;

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        SPM_IDLE,
        SPM_LEAD,
        SPM_SHIFT,
        SPM_TAIL,
        SPM_HOLD
    } spm_state_t;

endpackage

// >>> design/spm_clk_div.sv
// Purpose: Serial clock prescaler; marks mid-period and end-of-period.
// Assumes: i_run rises in the same cycle as a leading serial clock edge.
// Notes:   Period is prescale plus one, with two cycles as the floor.
`timescale 1ns/1ps
module spm_clk_div
(
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    // Control
    input  wire logic       i_run,
    input  wire logic [7:0] i_prescale,
    // Edge enables
    output logic            o_half,
    output logic            o_full
);

    logic [8:0] period;
    logic [8:0] first_len;
    logic [7:0] cnt_q;

    // ****************************************************************
    // Period and first-half length
    // ****************************************************************
    always_comb
    begin
        period = {1'b0, i_prescale} + 9'h001; // R01
        if (i_prescale == 8'h00)
        begin
            period = spm_pkg::MIN_PERIOD; // R01
        end
        first_len = period - {1'b0, period[8:1]};
    end

    // Enables at the end of each half
    assign o_half = i_run && ({1'b0, cnt_q} == first_len - 9'h001);
    assign o_full = i_run && ({1'b0, cnt_q} == period - 9'h001);

    // ****************************************************************
    // Cycle counter, cleared while stopped
    // ****************************************************************
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n || !i_run || o_full)
        begin
            cnt_q <= 8'h00;
        end
        else
        begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

endmodule

// >>> testbench/spm_slave_model.sv
// Purpose: Behavioural SPI slave for clock phase 0.
// Assumes: Polarity steady within a frame.
// Notes:   A released data line shows the inverse of its last bit.
`timescale 1ns/1ps
module spm_slave_model
(
    // Serial pins and data
    input  wire logic       i_sclk,
    input  wire logic       i_cs_n,
    input  wire logic       i_mosi,
    input  wire logic       i_pol,
    input  wire logic [7:0] i_tx,
    output logic            o_miso,
    output logic [7:0]      o_rx
);
    logic [7:0] sh = 8'h00;
    int         n  = 0;
    // Idle values
    initial o_miso = 1'b0;
    initial o_rx = 8'h00;
    // First bit goes out as select falls
    always @(negedge i_cs_n)
    begin
        sh = i_tx;
        n = 0;
        o_miso = sh[7];
    end
    // Released line never keeps a stale bit
    always @(posedge i_cs_n) o_miso = ~o_miso;
    // Capture on leading edge, shift on trailing
    always @(i_sclk)
    begin
        if (!i_cs_n && i_sclk != i_pol)
            o_rx = {o_rx[6:0], i_mosi};
        else if (!i_cs_n)
        begin
            n = n + 1;
            sh = (n == 8) ? i_tx : {sh[6:0], 1'b0};
            n = n % 8;
            o_miso = sh[7];
        end
    end
endmodule

// >>> testbench/spm_master_checker.sv
// Purpose: Timing assertions on the SPI master ports.
// Assumes: Configuration steady while a character runs.
// Notes:   Counters measure edge gaps, start-to-first-edge and done-to-release times.
`timescale 1ns/1ps
module spm_master_checker
(
    // Clock, reset and inputs
    input wire logic        i_sys_clk,
    input wire logic        i_rst_n,
    input wire logic [31:0] i_global_control_one,
    input wire logic [31:0] i_data_format_select,
    input wire logic [31:0] i_delay_config,
    input wire logic        i_chip_select_keep,
    input wire logic        i_start,
    // Outputs watched
    input wire logic        o_done,
    input wire logic        o_busy,
    input wire logic        o_serial_clock_pin,
    input wire logic        o_cs_n
);
    // ****************************************************************
    // Helper logic
    // ****************************************************************
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    logic        sclk_q, first_q, kq_q, kl_q;
    logic [15:0] gap_q, lead_q, tail_q;
    wire  [7:0]  ps  = i_data_format_select[15:8];
    wire         pol = i_data_format_select[17];
    wire  [8:0]  per = (ps == 8'h00) ? 9'h002 : {1'b0, ps} + 9'h001;
    wire  [15:0] lo  = {8'h00, per[8:1]};
    wire  [15:0] hi  = {7'h00, per} - lo;
    wire  [15:0] c2t = {8'h00, i_delay_config[31:24]};
    wire  [15:0] t2c = {8'h00, i_delay_config[23:16]};
    wire         edg = o_serial_clock_pin != sclk_q;
    wire         ok  = i_start && !o_busy && i_global_control_one[0]
                       && !i_data_format_select[16];
    // Edge gaps, lead and tail counts
    always_ff @(posedge i_sys_clk)
    begin
        sclk_q  <= o_serial_clock_pin;
        gap_q   <= edg ? 16'h0001 : gap_q + 16'h0001;
        lead_q  <= ok ? 16'h0001 : lead_q + 16'h0001;
        tail_q  <= o_done ? 16'h0001 : tail_q + 16'h0001;
        kq_q    <= ok ? i_chip_select_keep : kq_q;
        kl_q    <= ok ? i_chip_select_keep : kl_q;
        first_q <= !i_rst_n || o_cs_n || o_done || (first_q && !edg);
    end
    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_first_edge; first_q && edg && !o_cs_n; endsequence
    sequence s_release; $rose(o_cs_n) && !kl_q; endsequence
    // Pin trails the polarity bit by two cycles after a change
    property p_idle; o_cs_n && $past(o_cs_n) && $past(i_rst_n)
        && $stable(pol) && $past(pol, 2) == pol
        |-> o_serial_clock_pin == pol; endproperty
    a_idle: assert property (p_idle) else $error("idle clock level");
    property p_start; ok |=> !o_cs_n && o_busy; endproperty
    a_start: assert property (p_start) else $error("start lost");
    property p_refuse; i_start && !o_busy && o_cs_n && !(ok) |=> o_cs_n;
    endproperty
    a_refuse: assert property (p_refuse) else $error("bad start");
    property p_lead;
        s_first_edge |-> lead_q == c2t + (kq_q ? 16'h0004 : 16'h0003);
    endproperty
    a_lead: assert property (p_lead) else $error("lead time");
    property p_trail; edg && !o_cs_n && o_serial_clock_pin == pol
        |-> gap_q == hi; endproperty
    a_trail: assert property (p_trail) else $error("high half");
    property p_gap; edg && !first_q && !o_cs_n && o_serial_clock_pin != pol
        |-> gap_q == lo; endproperty
    a_gap: assert property (p_gap) else $error("low half");
    property p_done; $rose(o_done) |-> gap_q == lo && !o_cs_n; endproperty
    a_done: assert property (p_done) else $error("half hold");
    property p_tail; s_release |-> tail_q == t2c + 16'h0001; endproperty
    a_tail: assert property (p_tail) else $error("tail time");
endmodule
bind spm_master spm_master_checker u_spm_master_checker
(
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_global_control_one(i_global_control_one),
    .i_data_format_select(i_data_format_select),
    .i_delay_config(i_delay_config),
    .i_chip_select_keep(i_chip_select_keep), .i_start(i_start),
    .o_done(o_done), .o_busy(o_busy),
    .o_serial_clock_pin(o_serial_clock_pin), .o_cs_n(o_cs_n)
);

// >>> testbench/testbench.sv
// Purpose: Self-checking bench for the SPI master timing.
// Assumes: 25 MHz interface clock, slave model on the pins.
// Notes:   Cycle counts taken at falling clock edges.
`timescale 1ns/1ps
module testbench;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic        i_sys_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [31:0] gcr = 32'h0000_0001;
    logic [31:0] fmt = 32'h0000_0000;
    logic [31:0] dly = 32'h0000_0000;
    logic        keep = 1'b0;
    logic        start = 1'b0;
    logic [7:0]  tx = 8'h00;
    logic [7:0]  stx = 8'h00;
    logic [7:0]  rx, srx;
    logic        done, busy, sclk, mosi, miso, cs_n;
    int          errors = 0;
    int          checks_done = 0;
    // Clock
    always #(spm_pkg::CLK_PERIOD_NS / 2) i_sys_clk = ~i_sys_clk;
    spm_master u_spm_master
    (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_global_control_one(gcr), .i_data_format_select(fmt),
        .i_delay_config(dly), .i_chip_select_keep(keep),
        .i_start(start), .i_tx_data(tx), .o_rx_data(rx),
        .o_done(done), .o_busy(busy), .o_serial_clock_pin(sclk),
        .o_mosi(mosi), .i_miso(miso), .o_cs_n(cs_n)
    );
    spm_slave_model u_spm_slave_model
    (
        .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi), .i_pol(fmt[17]),
        .i_tx(stx), .o_miso(miso), .o_rx(srx)
    );
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic print_verdict;
        if (errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // One character, timed edge by edge
    task automatic xfer(input logic [7:0] ps, input logic pol,
                        input logic [7:0] c2t, input logic [7:0] t2c,
                        input logic kp, input logic hold, input logic [7:0] d);
        int   p, ld, c, fe, dn, ed;
        logic pv;
        p = (ps == 8'h00) ? 2 : ps + 1;
        ld = c2t + (kp ? 3 : 2);
        fe = -1;
        dn = -1;
        ed = 0;
        // Inputs change only just after a rising edge
        @(posedge i_sys_clk);
        fmt <= {14'h0000, pol, 1'b0, ps, 8'h00};
        dly <= {c2t, t2c, 16'h0000};
        keep <= kp;
        tx <= d;
        repeat (3) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        if (!hold) check(sclk, pol, "idle clock");
        pv = sclk;
        @(posedge i_sys_clk);
        start <= 1'b1;
        @(posedge i_sys_clk);
        start <= 1'b0;
        for (c = 0; c < 4000; c++)
        begin
            @(negedge i_sys_clk);
            if (sclk !== pv && fe < 0) fe = c;
            if (sclk !== pv) ed++;
            pv = sclk;
            if (done === 1'b1) dn = c;
            if (dn >= 0 && (kp || cs_n === 1'b1)) break;
        end
        if (c == 4000)
        begin
            errors++;
            print_verdict();
        end
        else
        begin
            check(fe, ld, "first clock edge");
            check(ed, 16, "clock edges");
            check(dn, ld + 8 * p, "done cycle");
            if (!kp) check(c - dn, t2c + 1, "select release");
            check(srx, d, "slave byte");
        end
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic s_refuse;
        @(posedge i_sys_clk);
        gcr <= 32'h0000_0000;
        start <= 1'b1;
        @(posedge i_sys_clk);
        gcr <= 32'h0000_0001;
        fmt <= 32'h0001_0100;
        @(posedge i_sys_clk);
        start <= 1'b0;
        @(negedge i_sys_clk);
        check({cs_n, busy}, 2'b10, "refused start");
    endtask
    task automatic s_walk;
        xfer(8'h01, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 8'ha5);
    endtask
    task automatic s_zero_pol;
        xfer(8'h00, 1'b1, 8'h03, 8'h02, 1'b0, 1'b0, 8'h3c);
    endtask
    task automatic s_keep;
        xfer(8'h02, 1'b1, 8'h01, 8'h04, 1'b1, 1'b0, 8'h7e);
        repeat (5) @(negedge i_sys_clk);
        check(cs_n, 1'b0, "select kept");
        xfer(8'h02, 1'b1, 8'h01, 8'h04, 1'b1, 1'b1, 8'he7);
        @(posedge i_sys_clk);
        keep <= 1'b0;
        for (int c = 0; c < 40 && cs_n !== 1'b1; c++) @(negedge i_sys_clk);
        check(cs_n, 1'b1, "select released");
    endtask
    task automatic s_slow;
        stx <= 8'hc3;
        xfer(8'hff, 1'b0, 8'hff, 8'hff, 1'b0, 1'b0, 8'h81);
        check(rx, 8'hc3, "received byte");
    endtask
    // Main sequence
    initial
    begin
        repeat (12) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        s_refuse();
        s_walk();
        s_zero_pol();
        s_keep();
        s_slow();
        print_verdict();
    end
endmodule
